/* pkg/srt_cfg.svh */
// Purpose: reset values for the set/reset and toggle relay
// Assumes: included by bare name
// Notes: definitions only
`ifndef SRT_CFG_SVH
`define SRT_CFG_SVH
`define SRT_Q_RST 1'h0
`define SRT_TRG_PREV_RST 1'h1
`endif

/* pkg/srt_pkg.sv */
// Purpose: types for the set/reset and toggle relay
// Assumes: nothing
// Notes: priority codes are one-hot
package srt_pkg;
   typedef enum logic [1:0]
   {
      clear_wins = 2'h1,
      set_wins = 2'h2
   } srt_prio_t;
   typedef struct packed
   {
      logic q;
   } srt_cell_st_t;
   typedef struct packed
   {
      logic trg_prev;
      logic toggle_req;
   } srt_main_st_t;
endpackage : srt_pkg

/* tb/srt_far_end.sv */
// Purpose: logic blocks that feed the relay inputs
// Assumes: word_i changes just after the rising clock edge
// Notes: lv_o is {trg, tog_clr, tog_set, latch_clr, latch_set, power_fail}
`timescale 1ns/1ns
`default_nettype none
module srt_far_end
(
   input wire logic clk_i, // system clock
   input wire logic [5:0] word_i, // levels asked for by the bench
   output logic [5:0] lv_o // levels driven to the relay
);
   logic pf_last = 1'b0;
   initial lv_o = 6'h00;
   always @(posedge clk_i)
   begin
      pf_last <= word_i[0];
      // trigger held low around a power failure so the edge history stays defined
      lv_o <= {word_i[5] & ~(word_i[0] | pf_last), word_i[4:0]};
   end
endmodule : srt_far_end
`default_nettype wire

/* tb/test_srt_relay.sv */
// Purpose: random check of srt_relay against a behavioural model
// Assumes: relay inputs arrive through srt_far_end
// Notes: two relays cover both priority and both retention choices
`timescale 1ns/1ns
`default_nettype none
module test_srt_relay
   import srt_pkg::*;
;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [5:0] word = 6'h00;
   logic [5:0] lv;
   wire logic [3:0] q;
   logic [31:0] r = 32'h7418B5C7;
   logic prev = 1'b1;
   logic edg;
   int ex[4] = '{-1, 0, 0, -1};
   int miscompares = 0;
   int n_tests = 0;
   always #25 clk_i = ~clk_i;
   srt_far_end far (.clk_i(clk_i), .word_i(word), .lv_o(lv));
   srt_relay #(.LATCH_RETAIN(1'b1), .TOGGLE_RETAIN(1'b0), .PRIO(set_wins)) dut (
      .clk_i(clk_i), .reset_i(reset_i), .power_fail_i(lv[0]), .latch_set_i(lv[1]),
      .latch_clr_i(lv[2]), .tog_set_i(lv[3]), .tog_clr_i(lv[4]), .tog_trg_i(lv[5]),
      .latch_q_o(q[0]), .tog_q_o(q[1]));
   srt_relay #(.LATCH_RETAIN(1'b0), .TOGGLE_RETAIN(1'b1), .PRIO(clear_wins)) dut_b (
      .clk_i(clk_i), .reset_i(reset_i), .power_fail_i(lv[0]), .latch_set_i(lv[1]),
      .latch_clr_i(lv[2]), .tog_set_i(lv[3]), .tog_clr_i(lv[4]), .tog_trg_i(lv[5]),
      .latch_q_o(q[2]), .tog_q_o(q[3]));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   // slots: 0 latch retained, 1 toggle set_wins, 2 latch, 3 toggle retained clear_wins
   function automatic int nx(input int k, input int v, input logic e);
      logic s;
      logic c;
      s = k[0] ? lv[3] : lv[1];
      c = k[0] ? lv[4] : lv[2];
      if (lv[0] && k != 0 && k != 3) return 0;
      if (s && c) return (k == 1) ? 1 : 0;
      if (c) return 0;
      if (s) return 1;
      if (k[0] && e) return (v < 0) ? -1 : 1 - v;
      return v;
   endfunction : nx
   task automatic chk(input logic got, input int exp);
      if (exp >= 0)
      begin
         n_tests++;
         if (got !== exp[0])
         begin
            miscompares++;
            $display("[ERR] %0t output %b expected %0d", $time, got, exp);
         end
      end
   endtask : chk
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge clk_i);
         if (!reset_i)
         begin
            edg = lv[5] & ~prev;
            prev = lv[5];
            for (int k = 0; k < 4; k++)
               ex[k] = nx(k, ex[k], edg);
         end
         r = xs(r);
         word <= {r[13], &r[12:10], &r[9:7], r[6] & r[5], r[4], &r[3:0]};
         reset_i <= (i >= 1500 && i < 1503);
         @(negedge clk_i);
         if (reset_i)
         begin
            ex[1] = 0;
            ex[2] = 0;
            prev = 1'b1;
         end
         chk(q[0], ex[0]);
         chk(q[1], ex[1]);
         chk(q[2], ex[2]);
         chk(q[3], ex[3]);
      end
      close_out();
   end
endmodule : test_srt_relay
`default_nettype wire

/* verilog/srt_relay.sv */
// Purpose: plain set/reset latch and toggle relay with priority and retention
// Assumes: all inputs come from logic on clk_i, so none is synchronised
// Notes: a power failure is a one-cycle pulse on power_fail_i
`timescale 1ns/1ns
`default_nettype none
`include "srt_cfg.svh"
module srt_relay
   import srt_pkg::*;
#(
   parameter bit LATCH_RETAIN = 1'b0,
   parameter bit TOGGLE_RETAIN = 1'b0,
   parameter srt_prio_t PRIO = clear_wins
)
(
   input wire logic clk_i, // 20 MHz system clock
   input wire logic reset_i, // async reset, active high
   input wire logic power_fail_i, // power failure pulse
   input wire logic latch_set_i, // latch set level
   input wire logic latch_clr_i, // latch clear level
   input wire logic tog_set_i, // toggle relay set level
   input wire logic tog_clr_i, // toggle relay clear level
   input wire logic tog_trg_i, // toggle trigger level
   output logic latch_q_o, // latch output, from flip-flop
   output logic tog_q_o // toggle relay output, from flip-flop
);
   srt_main_st_t st;
   srt_main_st_t next_st;
   logic next_latch;
   logic next_tog;
   logic trg_rise;

   assign trg_rise = tog_trg_i && !st.trg_prev;

   always_comb
   begin
      next_st = st;
      next_st.trg_prev = tog_trg_i;
      next_st.toggle_req = trg_rise && !tog_set_i && !tog_clr_i;
      // latch: clear dominates, otherwise set, otherwise hold
      if (latch_clr_i)
      begin
         next_latch = 1'h0;
      end
      else if (latch_set_i)
      begin
         next_latch = 1'h1;
      end
      else
      begin
         next_latch = latch_q_o;
      end
      // toggle relay: forcing inputs block the trigger entirely
      case ({tog_set_i, tog_clr_i})
         2'h0:
         begin
            next_tog = trg_rise ? !tog_q_o : tog_q_o;
         end
         2'h1:
         begin
            next_tog = 1'h0;
         end
         2'h2:
         begin
            next_tog = 1'h1;
         end
         2'h3:
         begin
            next_tog = (PRIO == set_wins);
         end
         default:
         begin
            next_tog = tog_q_o;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         st <= '{trg_prev: `SRT_TRG_PREV_RST, toggle_req: 1'h0};
      end
      else
      begin
         st <= next_st;
      end
   end

   // each output bit lives in its own cell with its own retention choice
   srt_store #(
      .RETAIN (LATCH_RETAIN)
   ) u_latch (
      .clk_i (clk_i),
      .reset_i (reset_i),
      .power_fail_i (power_fail_i),
      .d_i (next_latch),
      .q_o (latch_q_o)
   );

   srt_store #(
      .RETAIN (TOGGLE_RETAIN)
   ) u_toggle (
      .clk_i (clk_i),
      .reset_i (reset_i),
      .power_fail_i (power_fail_i),
      .d_i (next_tog),
      .q_o (tog_q_o)
   );

   sequence s_clean_rise;
      tog_trg_i && !st.trg_prev && !tog_set_i && !tog_clr_i;
   endsequence

   sequence s_held_high;
      tog_trg_i ##1 tog_trg_i;
   endsequence

   // the release edge is still a reset edge: inputs sampled there are not taken
   property p_latch_set;
      @(posedge clk_i) disable iff (reset_i)
      !reset_i && latch_set_i && !latch_clr_i && !power_fail_i |=> latch_q_o;
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch not set");

   property p_latch_clr;
      @(posedge clk_i) disable iff (reset_i)
      !reset_i && latch_clr_i && !latch_set_i |=> !latch_q_o;
   endproperty
   a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");

   property p_latch_both;
      @(posedge clk_i) disable iff (reset_i)
      !reset_i && latch_clr_i && latch_set_i |=> !latch_q_o;
   endproperty
   a_latch_both: assert property (p_latch_both) else $error("set beat clear");

   property p_latch_hold;
      @(posedge clk_i) disable iff (reset_i)
      !latch_set_i && !latch_clr_i && (!power_fail_i || LATCH_RETAIN)
      |=> latch_q_o == $past(latch_q_o);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch lost value");

   property p_tog_flip;
      @(posedge clk_i) disable iff (reset_i)
      s_clean_rise and !power_fail_i |=> tog_q_o != $past(tog_q_o) && st.toggle_req;
   endproperty
   a_tog_flip: assert property (p_tog_flip) else $error("trigger did not toggle");

   property p_tog_forced;
      @(posedge clk_i) disable iff (reset_i)
      !reset_i && (tog_set_i || tog_clr_i) && !power_fail_i
      |=> tog_q_o == ($past(tog_set_i) && !($past(tog_clr_i) && PRIO == clear_wins));
   endproperty
   a_tog_forced: assert property (p_tog_forced) else $error("forcing wrong");

   property p_tog_idle;
      @(posedge clk_i) disable iff (reset_i)
      !tog_set_i && !tog_clr_i && !power_fail_i && !(tog_trg_i && !st.trg_prev)
      |=> $stable(tog_q_o);
   endproperty
   a_tog_idle: assert property (p_tog_idle) else $error("toggle moved");

   property p_single_req;
      @(posedge clk_i) disable iff (reset_i)
      s_held_high |=> !st.toggle_req;
   endproperty
   a_single_req: assert property (p_single_req) else $error("repeat toggle");

   property p_pf_clear;
      @(posedge clk_i) disable iff (reset_i)
      power_fail_i && !TOGGLE_RETAIN |=> !tog_q_o [*1];
   endproperty
   a_pf_clear: assert property (p_pf_clear) else $error("toggle kept after failure");

   property p_like_latch;
      @(posedge clk_i) disable iff (reset_i)
      !reset_i && !tog_trg_i && PRIO == clear_wins && tog_set_i && tog_clr_i |=> !tog_q_o;
   endproperty
   a_like_latch: assert property (p_like_latch) else $error("not latch-like");

   property p_latch_pf;
      @(posedge clk_i) disable iff (reset_i)
      power_fail_i && !LATCH_RETAIN |=> !latch_q_o;
   endproperty
   a_latch_pf: assert property (p_latch_pf) else $error("latch kept after failure");

   property p_tog_keep;
      @(posedge clk_i) disable iff (reset_i)
      power_fail_i && TOGGLE_RETAIN && !tog_set_i && !tog_clr_i && !(tog_trg_i && !st.trg_prev)
      |=> $stable(tog_q_o);
   endproperty
   a_tog_keep: assert property (p_tog_keep) else $error("retained toggle lost value");

   // reset only ever clears the non-retentive output bits; retentive output bits stand still
   property p_rst_latch;
      @(posedge clk_i)
      reset_i |=> (LATCH_RETAIN ? latch_q_o == $past(latch_q_o) : !latch_q_o);
   endproperty
   a_rst_latch: assert property (p_rst_latch) else $error("reset disturbed latch");

   property p_rst_tog;
      @(posedge clk_i)
      reset_i |=> (TOGGLE_RETAIN ? tog_q_o == $past(tog_q_o) : !tog_q_o);
   endproperty
   a_rst_tog: assert property (p_rst_tog) else $error("reset disturbed toggle");
endmodule : srt_relay
`default_nettype wire

/* verilog/srt_store.sv */
// Purpose: one stored output bit, optionally retentive
// Assumes: power_fail_i comes from logic on clk_i
// Notes: a retentive cell ignores power_fail_i and only freezes while reset_i is high
`timescale 1ns/1ns
`default_nettype none
`include "srt_cfg.svh"
module srt_store
   import srt_pkg::*;
#(
   parameter bit RETAIN = 1'b0
)
(
   input wire logic clk_i, // system clock
   input wire logic reset_i, // async reset for a non-retentive cell, freeze for a retentive one; active high
   input wire logic power_fail_i, // power failure event
   input wire logic d_i, // new value of the bit
   output logic q_o // stored bit
);
   // power-up contents; the retentive branch never resets it
   srt_cell_st_t st = '{q: `SRT_Q_RST};
   srt_cell_st_t next_st;
   always_comb
   begin
      next_st = st;
      next_st.q = d_i;
      if (power_fail_i && !RETAIN)
      begin
         next_st.q = `SRT_Q_RST;
      end
   end
   generate
      if (RETAIN)
      begin : g_keep
         // no reset: the value is meant to survive, it only freezes while reset_i is high
         always_ff @(posedge clk_i)
         begin
            if (!reset_i)
            begin
               st <= next_st;
            end
         end
      end
      else
      begin : g_clear
         always_ff @(posedge clk_i or posedge reset_i)
         begin
            if (reset_i)
            begin
               st <= '{q: `SRT_Q_RST};
            end
            else
            begin
               st <= next_st;
            end
         end
      end
   endgenerate
   assign q_o = st.q;
endmodule : srt_store
`default_nettype wire
